// ### pin_parity_regs.svh
// Purpose: Offsets, field positions and reset values for the pin parity block
// Assumes: AXI4-Lite register bus, 32-bit data, byte addresses
// Notes:   Definitions only
`ifndef PIN_PARITY_REGS_SVH
`define PIN_PARITY_REGS_SVH

`define OFF_CTRL        12'h000
`define OFF_STATUS      12'h004
`define OFF_ERRCNT      12'h008
`define OFF_TRAP        12'h00C

`define CTRL_CLR_BIT    0
`define CTRL_INJ_BIT    1
`define CTRL_RESET      32'h0000_0000

`define ST_INST_BIT     0
`define ST_LOAD_BIT     1
`define ST_FP_BIT       2
`define ST_CMP_BIT      3

`define TRAP_INST_PAR   8'h61
`define TRAP_LOAD_PAR   8'h63
`define TRAP_FP_DIS     8'h04

`define AXI_OKAY        2'b00
`define AXI_SLVERR      2'b10

`endif

// ### pin_parity_pkg.sv
// Purpose: Types shared by the pin parity block
// Assumes: Nothing beyond the header
// Notes:   Bus groups travel as packed structs
package pin_parity_pkg;

	typedef struct packed {
		logic       double_transfer_flag;
		logic       atomic_load_store_flag;
		logic       lock;
		logic       rd;
		logic       we_n;
		logic       write_advance_flag;
	} mem_ctrl_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [7:0]  address_space_identifier;
		logic [1:0]  size;
	} addr_bus_t;

	typedef struct packed {
		logic [1:0] fcc;
		logic       fccv;
		logic       fexc;
		logic       fhold;
		logic       fp;
	} fp_ctrl_t;

	typedef enum logic [1:0] {
		TRAP_NONE = 2'b00,
		TRAP_INST = 2'b01,
		TRAP_LOAD = 2'b10,
		TRAP_FPD  = 2'b11
	} trap_kind_t;

endpackage

// ### pin_parity_and_lockstep_check.sv
// Purpose: Odd parity on pins plus master/checker compare, with AXI4-Lite
// Assumes: One clock, synchronous active-low reset, pin inputs synchronous
// Notes:   Pins are in/out/oe triples; the bench resolves the wires
`timescale 1ns/1ps
`include "pin_parity_regs.svh"

module pin_parity_and_lockstep_check #(
	parameter int ADDR_W = 12
) (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [ADDR_W-1:0]           s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Core side
	input  wire pin_parity_pkg::mem_ctrl_t   core_mem_ctrl,
	input  wire pin_parity_pkg::addr_bus_t   core_addr,
	input  wire logic [31:0]                 core_store_data,
	input  wire logic                        core_store,
	input  wire logic                        core_inst_fetch,
	input  wire logic                        core_load,
	input  wire logic                        fp_conditional_branch,
	// Enables and modes
	input  wire logic                        control_output_enable_n,
	input  wire logic                        address_output_enable_n,
	input  wire logic                        data_output_enable_n,
	input  wire logic                        test_output_enable_n,
	input  wire logic                        std_fpu_mode_n,
	input  wire logic                        checker_mode_n,
	// Pins
	input  wire pin_parity_pkg::mem_ctrl_t   mem_ctrl_in,
	output pin_parity_pkg::mem_ctrl_t        mem_ctrl_out,
	output logic                             mem_ctrl_oe,
	output logic                             mem_ctrl_parity_out,
	output logic                             mem_ctrl_parity_oe,
	input  wire pin_parity_pkg::addr_bus_t   addr_in,
	output pin_parity_pkg::addr_bus_t        addr_out,
	output logic                             addr_oe,
	output logic                             address_parity_out,
	output logic                             space_size_parity_out,
	output logic                             addr_parity_oe,
	input  wire logic [31:0]                 data_in,
	output logic [31:0]                      data_out,
	output logic                             data_oe,
	input  wire logic                        data_parity_line_in,
	output logic                             data_parity_line_out,
	output logic                             data_parity_line_oe,
	input  wire pin_parity_pkg::fp_ctrl_t    fp_ctrl_in,
	input  wire logic                        fp_to_int_parity_in,
	// Results
	output logic                             hardware_error_n,
	output logic                             trap_req,
	output logic [7:0]                       trap_type,
	output logic                             trap_late,
	output logic                             compare_error_n,
	output logic                             compare_error_oe
);
	import pin_parity_pkg::*;

	// Register decode reads twelve address bits; narrower buses would
	// silently alias, so they are refused at elaboration
	if (ADDR_W < 12) begin : g_addr_chk
		$error("ADDR_W too small for the register map");
	end

	function automatic logic odd_par(input logic [63:0] v);
		odd_par = ~(^v);
	endfunction

	logic       checker_mode;
	logic       in_reset;
	logic       ctl_en, adr_en, dat_en, tst_en;
	logic       mpar_nxt, address_parity_out_nxt, spar_nxt, data_parity_line_nxt;
	logic       inst_err, load_err, fp_err;
	logic       mismatch;
	logic       inj_r;
	logic [3:0] status_r;
	logic [15:0] errcnt_r;
	trap_kind_t last_trap_r;

	assign checker_mode = ~checker_mode_n;
	assign in_reset = ~aresetn;
	assign ctl_en = ~checker_mode & (~control_output_enable_n |
		~test_output_enable_n);
	assign adr_en = ~checker_mode & (~address_output_enable_n |
		~test_output_enable_n);
	assign dat_en = ~checker_mode & core_store &
		(~data_output_enable_n | ~test_output_enable_n);
	assign tst_en = ~test_output_enable_n;

	assign mpar_nxt = odd_par({58'd0, core_mem_ctrl});
	assign address_parity_out_nxt = odd_par({32'd0, core_addr.addr});
	assign spar_nxt = odd_par({54'd0, core_addr.address_space_identifier,
		core_addr.size});
	assign data_parity_line_nxt = odd_par({32'd0, core_store_data}) ^ inj_r;

	// std FPU mode ignores the data parity pin
	assign inst_err = ~in_reset & std_fpu_mode_n & core_inst_fetch &
		(odd_par({32'd0, data_in}) != data_parity_line_in);
	assign load_err = ~in_reset & std_fpu_mode_n & core_load &
		(odd_par({32'd0, data_in}) != data_parity_line_in);
	// FP control parity only on FP branch
	assign fp_err = ~in_reset & std_fpu_mode_n & fp_conditional_branch &
		(odd_par({58'd0, fp_ctrl_in}) != fp_to_int_parity_in);
	// inbound memory-controller control lines feed only the compare, no parity checker
	// no coprocessor lines here at all

	// Pins show what was registered last cycle, so each group's compare
	// enable is registered alongside; comparing with the live core value
	// would flag every change of the core as a mismatch
	logic cmp_ctl_r, cmp_adr_r, cmp_dat_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_ctl_r <= 1'b0;
			cmp_adr_r <= 1'b0;
			cmp_dat_r <= 1'b0;
		end else begin
			cmp_ctl_r <= ~control_output_enable_n | tst_en;
			cmp_adr_r <= ~address_output_enable_n | tst_en;
			cmp_dat_r <= core_store & (~data_output_enable_n | tst_en);
		end
	end

	// only buffers this unit would drive take part
	// also catches shorts on a lone master
	always_comb begin
		mismatch = 1'b0;
		if (aresetn) begin
			if (cmp_ctl_r)
				mismatch = mismatch | (mem_ctrl_in != mem_ctrl_out);
			if (cmp_adr_r)
				mismatch = mismatch | (addr_in != addr_out);
			if (cmp_dat_r)
				mismatch = mismatch | (data_in != data_out);
		end
	end

	// Pin drivers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_ctrl_out        <= '0;
			mem_ctrl_oe         <= 1'b0;
			mem_ctrl_parity_out <= 1'b0;
			mem_ctrl_parity_oe  <= 1'b0;
		end else begin
			mem_ctrl_out        <= core_mem_ctrl;
			mem_ctrl_oe         <= ctl_en;
			mem_ctrl_parity_out <= mpar_nxt;
			// parity enabled by control or test
			mem_ctrl_parity_oe  <= ctl_en;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_out              <= '0;
			addr_oe               <= 1'b0;
			address_parity_out    <= 1'b0;
			space_size_parity_out <= 1'b0;
			addr_parity_oe        <= 1'b0;
		end else begin
			addr_out              <= core_addr;
			addr_oe               <= adr_en;
			address_parity_out    <= address_parity_out_nxt;
			space_size_parity_out <= spar_nxt;
			// parity gated by address or test
			addr_parity_oe        <= adr_en;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_out             <= '0;
			data_oe              <= 1'b0;
			data_parity_line_out <= 1'b0;
			data_parity_line_oe  <= 1'b0;
		end else begin
			data_out             <= core_store_data;
			data_oe              <= dat_en;
			data_parity_line_out <= data_parity_line_nxt;
			data_parity_line_oe  <= dat_en;
		end
	end

	// load error is late; fetch wins over load
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trap_req         <= 1'b0;
			trap_type        <= 8'h00;
			trap_late        <= 1'b0;
			hardware_error_n <= 1'b1;
		end else begin
			trap_req         <= inst_err | load_err | fp_err;
			trap_late        <= ~inst_err & load_err;
			hardware_error_n <= ~(inst_err | load_err);
			if (inst_err)
				trap_type <= `TRAP_INST_PAR;
			else if (load_err)
				trap_type <= `TRAP_LOAD_PAR;
			else if (fp_err)
				trap_type <= `TRAP_FP_DIS;
			else
				trap_type <= 8'h00;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			compare_error_n  <= 1'b1;
			compare_error_oe <= 1'b0;
		end else begin
			compare_error_n  <= ~mismatch;
			compare_error_oe <= tst_en;
		end
	end

	// Sticky status and counter; set wins over clear
	logic       wr_fire, clr_req;
	logic [3:0] ev;
	assign ev = {mismatch, fp_err, load_err, inst_err};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_r    <= '0;
			errcnt_r    <= '0;
			last_trap_r <= TRAP_NONE;
		end else begin
			status_r <= (clr_req ? 4'h0 : status_r) | ev;
			if (clr_req)
				errcnt_r <= {15'd0, |ev[2:0]};
			else if ((|ev[2:0]) && errcnt_r != 16'hFFFF)
				errcnt_r <= errcnt_r + 16'd1;
			if (inst_err)
				last_trap_r <= TRAP_INST;
			else if (load_err)
				last_trap_r <= TRAP_LOAD;
			else if (fp_err)
				last_trap_r <= TRAP_FPD;
		end
	end

	// AXI4-Lite write: accept address and data in either order
	logic              aw_held, w_held;
	logic [ADDR_W-1:0] aw_r;
	logic [31:0]       wd_r;
	logic [3:0]        ws_r;
	assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
	assign clr_req = wr_fire && aw_r[11:0] == `OFF_CTRL && ws_r[0] &&
		wd_r[`CTRL_CLR_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_r          <= '0;
			wd_r          <= '0;
			ws_r          <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `AXI_OKAY;
			inj_r         <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held <= 1'b1;
				aw_r    <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held <= 1'b1;
				wd_r   <= s_axi_wdata;
				ws_r   <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_r[11:0] == `OFF_CTRL) begin
					s_axi_bresp <= `AXI_OKAY;
					if (ws_r[0])
						inj_r <= wd_r[`CTRL_INJ_BIT];
				end else begin
					s_axi_bresp <= `AXI_SLVERR;
				end
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `AXI_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `AXI_OKAY;
				unique case (s_axi_araddr[11:0])
				`OFF_CTRL:   s_axi_rdata <= {30'd0, inj_r, 1'b0};
				`OFF_STATUS: s_axi_rdata <= {28'd0, status_r};
				`OFF_ERRCNT: s_axi_rdata <= {16'd0, errcnt_r};
				`OFF_TRAP:   s_axi_rdata <= {28'd0, ~std_fpu_mode_n,
					checker_mode, last_trap_r};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= `AXI_SLVERR;
				end
				endcase
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// ### pin_parity_chk.sv
// Purpose: Port-level checks on the pin parity block
// Assumes: Pin drives and error flags lag their cause by one clock
// Notes:   Odd parity means the xor over word and parity bit is one
`timescale 1ns/1ps
`include "pin_parity_regs.svh"
module pin_parity_chk (
	input wire logic                      aclk,
	input wire logic                      aresetn,
	input wire pin_parity_pkg::mem_ctrl_t core_mem_ctrl,
	input wire pin_parity_pkg::addr_bus_t core_addr,
	input wire logic [31:0]               core_store_data,
	input wire logic                      core_inst_fetch,
	input wire logic                      core_load,
	input wire logic                      fp_conditional_branch,
	input wire logic                      test_output_enable_n,
	input wire logic                      std_fpu_mode_n,
	input wire logic [31:0]               data_in,
	input wire logic                      data_parity_line_in,
	input wire pin_parity_pkg::fp_ctrl_t  fp_ctrl_in,
	input wire logic                      fp_to_int_parity_in,
	input wire logic                      mem_ctrl_parity_out,
	input wire logic                      mem_ctrl_parity_oe,
	input wire logic                      address_parity_out,
	input wire logic                      space_size_parity_out,
	input wire logic                      addr_parity_oe,
	input wire logic                      data_parity_line_out,
	input wire logic                      data_parity_line_oe,
	input wire logic                      hardware_error_n,
	input wire logic                      trap_req,
	input wire logic [7:0]                trap_type,
	input wire logic                      trap_late,
	input wire logic                      compare_error_oe
);
	import pin_parity_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic bad_d;
	logic bad_f;
	assign bad_d = ~^{data_in, data_parity_line_in};
	assign bad_f = ~^{fp_ctrl_in, fp_to_int_parity_in};
	property p_mcp; mem_ctrl_parity_oe |->
		^{mem_ctrl_parity_out, $past(core_mem_ctrl)}; endproperty
	a_mcp: assert property (p_mcp) else $error("ctrl parity wrong");
	property p_adp; addr_parity_oe |-> ^{address_parity_out,
		$past(core_addr.addr)} && ^{space_size_parity_out,
		$past(core_addr[9:0])}; endproperty
	a_adp: assert property (p_adp) else $error("addr parity wrong");
	property p_dp; data_parity_line_oe |-> ^{data_parity_line_out,
		$past(core_store_data)}; endproperty
	a_dp: assert property (p_dp) else $error("store parity wrong");
	property p_ins; core_inst_fetch && std_fpu_mode_n && bad_d |=> trap_req
		&& trap_type == `TRAP_INST_PAR && !hardware_error_n; endproperty
	a_ins: assert property (p_ins) else $error("fetch trap wrong");
	property p_ld; core_load && !core_inst_fetch && std_fpu_mode_n && bad_d
		|=> trap_req && trap_late && trap_type == `TRAP_LOAD_PAR; endproperty
	a_ld: assert property (p_ld) else $error("load trap wrong");
	property p_fp; fp_conditional_branch && !core_inst_fetch && !core_load
		&& std_fpu_mode_n && bad_f |=> trap_req && trap_type == `TRAP_FP_DIS;
	endproperty
	a_fp: assert property (p_fp) else $error("fp trap wrong");
	property p_cause; trap_req |-> $past(aresetn) && $past(core_inst_fetch ||
		core_load || fp_conditional_branch && std_fpu_mode_n); endproperty
	a_cause: assert property (p_cause) else $error("trap uncaused");
	property p_ceoe; $past(aresetn) |->
		compare_error_oe == !$past(test_output_enable_n); endproperty
	a_ceoe: assert property (p_ceoe) else $error("cmp oe wrong");
endmodule
bind pin_parity_and_lockstep_check pin_parity_chk u_chk (.*);

// ### far_side_model.sv
// Purpose: Memory controller and FPU pins seen from outside the block
// Assumes: Undriven lines sit high through their pull-ups
// Notes:   Bad parity or a shorted pin only when the bench asks
`timescale 1ns/1ps
module far_side_model (
	input wire logic                      rd_en,
	input wire logic [31:0]               rd_word,
	input wire logic                      rd_bad,
	input wire pin_parity_pkg::fp_ctrl_t  fp_word,
	input wire logic                      fp_bad,
	input wire logic                      short0,
	input wire logic                      mst_en,
	input wire pin_parity_pkg::addr_bus_t mst_addr,
	input wire pin_parity_pkg::addr_bus_t addr_out,
	input wire logic                      addr_oe,
	input wire logic [31:0]               data_out,
	input wire logic                      data_oe,
	input wire logic                      data_parity_line_out,
	input wire logic                      data_parity_line_oe,
	output pin_parity_pkg::addr_bus_t     addr_in,
	output logic [31:0]                   data_in,
	output logic                          data_parity_line_in,
	output pin_parity_pkg::fp_ctrl_t      fp_ctrl_in,
	output logic                          fp_to_int_parity_in
);
	assign data_parity_line_in = data_parity_line_oe ? data_parity_line_out :
		rd_en ? (~^rd_word) ^ rd_bad : 1'b1;
	assign data_in = data_oe ? data_out : rd_en ? rd_word : '1;
	// Short to ground on the lowest pin, or a master in the block's place
	assign addr_in = addr_oe ? addr_out & ~{41'h0, short0} :
		mst_en ? mst_addr : '1;
	assign fp_ctrl_in = fp_word;
	assign fp_to_int_parity_in = (~^fp_word) ^ fp_bad;
endmodule

// ### pin_parity_and_lockstep_check_tb_top.sv
// Purpose: Self-checking bench for the pin parity and lockstep block
// Assumes: 250 MHz clock, inputs change right after rising edges
// Notes:   Far side pins other than mem_ctrl_in come from far_side_model
`timescale 1ns/1ps
`include "pin_parity_regs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module pin_parity_and_lockstep_check_tb_top;
	import pin_parity_pkg::*;
	mem_ctrl_t   core_mem_ctrl, mem_ctrl_in, mem_ctrl_out;
	addr_bus_t   core_addr, addr_in, addr_out, mst_addr;
	fp_ctrl_t    fp_ctrl_in, fp_word;
	logic [31:0] s_axi_wdata, s_axi_rdata, core_store_data, data_in;
	logic [31:0] data_out, rd_word, rd;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [7:0]  trap_type;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, core_store;
	logic core_inst_fetch, core_load, fp_conditional_branch, mem_ctrl_oe;
	logic control_output_enable_n, address_output_enable_n, addr_oe;
	logic data_output_enable_n, test_output_enable_n, std_fpu_mode_n;
	logic checker_mode_n, mem_ctrl_parity_out, mem_ctrl_parity_oe;
	logic address_parity_out, space_size_parity_out, addr_parity_oe;
	logic data_oe, data_parity_line_in, data_parity_line_out, trap_late;
	logic data_parity_line_oe, fp_to_int_parity_in, hardware_error_n;
	logic trap_req, compare_error_n, compare_error_oe, mst_en, rd_en;
	logic rd_bad, fp_bad, short0;
	int   fails, num_checks;

	always #2 aclk = ~aclk;
	assign mem_ctrl_in = mem_ctrl_oe ? mem_ctrl_out : '1;
	pin_parity_and_lockstep_check u_dut (.*);
	far_side_model u_far (.*);

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 40);
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
		if (s_axi_bvalid !== 1'b1) begin fails++; test_done(); end
	endtask

	task automatic rdr(input logic [11:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 40);
		s_axi_rready <= 1'b0;
		rsp = s_axi_rresp;
		rd = s_axi_rdata;
		if (s_axi_rvalid !== 1'b1) begin fails++; test_done(); end
	endtask

	// Mode pins move only while reset is held
	task automatic do_reset(input logic std_n, input logic chk_n);
		@(posedge aclk);
		aresetn <= 1'b0;
		std_fpu_mode_n <= std_n;
		checker_mode_n <= chk_n;
		core_load <= 1'b1;
		rd_en <= 1'b1;
		rd_bad <= 1'b1;
		repeat (8) @(posedge aclk);
		`CHK("rst trap", 1'b0, trap_req)
		aresetn <= 1'b1;
		core_load <= 1'b0;
		rd_en <= 1'b0;
		rd_bad <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic t_regs();
		rdr(`OFF_ERRCNT);
		`CHK("errcnt", 32'h0000_0000, rd)
		wr(12'h010, 32'h0000_0001);
		`CHK("unmapped wr", `AXI_SLVERR, rsp)
		rdr(12'h010);
		`CHK("unmapped rd", 32'h0000_0000, rd)
		wr(`OFF_STATUS, 32'hFFFF_FFFF);
		`CHK("ro wr", `AXI_SLVERR, rsp)
		wr(`OFF_CTRL, 32'h0000_0002);
		rdr(`OFF_CTRL);
		`CHK("ctrl rw", 32'h0000_0002, rd)
		wr(`OFF_CTRL, 32'h0000_0000);
		$display("regs done");
	endtask

	task automatic t_out();
		logic [31:0] v[3] = '{32'h0000_0000, 32'hFFFF_FFFF, 32'h8421_0F01};
		foreach (v[i]) begin
			@(posedge aclk);
			core_mem_ctrl <= v[i][5:0];
			core_addr <= {v[i], v[i][9:0]};
			core_store_data <= ~v[i];
			core_store <= 1'b1;
			repeat (2) @(posedge aclk);
			`CHK("ctrl par", ~^v[i][5:0], mem_ctrl_parity_out)
			`CHK("addr par", ~^v[i], address_parity_out)
			`CHK("asi par", ~^v[i][9:0], space_size_parity_out)
			`CHK("store par", ~^v[i], data_parity_line_out)
			`CHK("store oe", 1'b1, data_oe)
			`CHK("store data", ~v[i], data_out)
			`CHK("addr out", {v[i], v[i][9:0]}, addr_out)
			`CHK("ctrl out", v[i][5:0], mem_ctrl_out)
		end
		control_output_enable_n <= 1'b1;
		address_output_enable_n <= 1'b1;
		test_output_enable_n <= 1'b1;
		core_store <= 1'b0;
		repeat (3) @(posedge aclk);
		`CHK("ctrl par oe", 1'b0, mem_ctrl_parity_oe)
		`CHK("ctrl oe", 1'b0, mem_ctrl_oe)
		`CHK("no cmp off", 1'b1, compare_error_n)
		`CHK("addr par oe", 1'b0, addr_parity_oe)
		`CHK("cmp oe", 1'b0, compare_error_oe)
		control_output_enable_n <= 1'b0;
		address_output_enable_n <= 1'b0;
		test_output_enable_n <= 1'b0;
		$display("out done");
	endtask

	task automatic take(input logic [2:0] k, input logic bad,
		input logic [7:0] ty);
		@(posedge aclk);
		{core_inst_fetch, core_load, fp_conditional_branch} <= k;
		rd_en <= 1'b1;
		rd_word <= 32'h0F0F_1234;
		rd_bad <= bad;
		fp_bad <= bad;
		@(posedge aclk);
		{core_inst_fetch, core_load, fp_conditional_branch} <= 3'b000;
		rd_en <= 1'b0;
		@(posedge aclk);
		`CHK("trap", (ty != 8'h00), trap_req)
		if (ty != 8'h00) begin
			`CHK("type", ty, trap_type)
			`CHK("late", (ty == `TRAP_LOAD_PAR), trap_late)
		end
		// Only the data traps carry the hardware error line
		`CHK("hwerr", !(ty == `TRAP_INST_PAR || ty == `TRAP_LOAD_PAR), hardware_error_n)
	endtask

	task automatic t_in();
		take(3'b010, 1'b1, `TRAP_LOAD_PAR);
		take(3'b100, 1'b1, `TRAP_INST_PAR);
		take(3'b110, 1'b1, `TRAP_INST_PAR);
		take(3'b001, 1'b1, `TRAP_FP_DIS);
		take(3'b000, 1'b1, 8'h00);
		take(3'b010, 1'b0, 8'h00);
		rdr(`OFF_STATUS);
		`CHK("status", 32'h0000_0007, rd)
		rdr(`OFF_ERRCNT);
		`CHK("errcnt", 32'h0000_0004, rd)
		wr(`OFF_CTRL, 32'h0000_0001);
		rdr(`OFF_STATUS);
		`CHK("cleared", 32'h0000_0000, rd)
		do_reset(1'b0, 1'b1);
		take(3'b001, 1'b1, 8'h00);
		take(3'b010, 1'b1, 8'h00);
		do_reset(1'b1, 1'b1);
		$display("in done");
	endtask

	task automatic t_cmp();
		@(posedge aclk);
		core_mem_ctrl <= 6'h3F;
		core_addr <= '{32'h0000_0000, 8'h00, 2'h1};
		mst_addr <= '{32'h0000_0000, 8'h00, 2'h1};
		short0 <= 1'b1;
		repeat (3) @(posedge aclk);
		`CHK("short", 1'b0, compare_error_n)
		short0 <= 1'b0;
		repeat (3) @(posedge aclk);
		`CHK("short gone", 1'b1, compare_error_n)
		do_reset(1'b1, 1'b0);
		mst_en <= 1'b1;
		repeat (3) @(posedge aclk);
		`CHK("float addr", 1'b0, addr_oe)
		`CHK("float ctrl", 1'b0, mem_ctrl_oe)
		`CHK("match", 1'b1, compare_error_n)
		mst_addr <= '{32'h0000_0010, 8'h00, 2'h1};
		repeat (3) @(posedge aclk);
		`CHK("mismatch", 1'b0, compare_error_n)
		mst_en <= 1'b0;
		do_reset(1'b1, 1'b1);
		$display("cmp done");
	endtask

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, core_store, core_inst_fetch, core_load} = '0;
		{fp_conditional_branch, mst_en, rd_en, rd_bad, fp_bad} = '0;
		{short0, control_output_enable_n, address_output_enable_n} = '0;
		{data_output_enable_n, test_output_enable_n} = '0;
		{std_fpu_mode_n, checker_mode_n} = 2'b11;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd_word} = '0;
		s_axi_wstrb = 4'hF;
		{core_mem_ctrl, core_addr, core_store_data, mst_addr} = '0;
		fp_word = 6'h2A;
		fails = 0;
		num_checks = 0;
		do_reset(1'b1, 1'b1);
		t_regs();
		t_out();
		t_in();
		t_cmp();
		test_done();
	end
endmodule
